// ===== logic/clk_ctrl_pkg.sv
// constants for the clock generation and output control block
package clk_ctrl_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] LOOP_CTRL_OFS = 8'h00;
    localparam logic [7:0] OP_MODE_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int FACTOR_W = 8;
    localparam int MULT_LSB = 0;
    localparam int DIV_LSB = 8;
    localparam int LOOP_EN_BIT = 16;
    localparam int ASYNC_ARB_BIT = 0;
    localparam int ST_CLK_BIT = 0;
    localparam int ST_NMI_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_GRANT_BIT = 3;
    localparam int ST_ASYNC_BIT = 4;
    localparam int ST_EN_BIT = 5;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [FACTOR_W-1:0] FACTOR_RESET = 8'h01;
    localparam logic [FACTOR_W-1:0] FACTOR_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ************************************************************
    // clock rate of mclk
    // ************************************************************
    localparam int MCLK_FREQ_HZ = 20_000_000;

    // bus slave phases, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_t;

endpackage : clk_ctrl_pkg

// ===== logic/level_sync.sv
// two-stage synchroniser for a group of levels
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // ************************************************************
    // one pair of flops per bit
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // first flop feeds only the second one
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    stage1_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1_reg[i] <= async_in[i];
                    sync_out[i] <= stage1_reg[i];
                end
            end
        end
    endgenerate

endmodule : level_sync

// ===== logic/clock_pll_output_control.sv
// clock generation, clock output, loop strap, nmi and arbitration mode
//
// Contract
// (RULE1) clock output edges follow the internal core clock phase
// (RULE2) loop on with both factors one: clock output also follows input clock
// (RULE3) loop off: clock output runs at half the input clock frequency
// (RULE4) during reset the init pin level is copied into the loop enable bit
// (RULE5) after reset a falling nmi edge requests, synchronised to clock output
// (RULE6) async arbitration bit set: busy and grant need no clock-output timing
// (RULE7) outside parts must not time from clock output above 100 MHz
// (RULE8) loop on: core frequency is input times multiplier over divider
`timescale 1ns/1ps
module clock_pll_output_control (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_in,
    output logic crystal_drive_out,
    output logic core_clock_out,
    input wire logic loop_init_pin,
    input wire logic nmi_n,
    output logic nmi_request,
    input wire logic bus_busy,
    input wire logic bus_grant,
    output logic bus_busy_seen,
    output logic bus_grant_seen,
    output logic async_arb_mode
);
    import clk_ctrl_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic loop_enable_bit;
    logic [FACTOR_W-1:0] mult_reg;
    logic [FACTOR_W-1:0] div_reg;
    logic async_arbitration_enable;
    logic ext_prev_reg;
    logic [FACTOR_W+1:0] acc_reg;
    logic [FACTOR_W+1:0] acc_next;
    logic nmi_prev_reg;
    logic nmi_pend_reg;
    logic [1:0] arb_sync;
    bus_state_t bus_state_reg;

    // zero factor behaves as one so the ratio never stalls
    function automatic logic [FACTOR_W-1:0] eff_factor(input logic [FACTOR_W-1:0] f);
        eff_factor = (f == FACTOR_ZERO) ? FACTOR_RESET : f;
    endfunction : eff_factor

    // ************************************************************
    // input clock edge detection
    // ************************************************************
    logic ext_edge;
    logic ext_rise;
    logic unity;
    logic [FACTOR_W-1:0] mf;
    logic [FACTOR_W-1:0] df;
    logic [FACTOR_W+1:0] acc_sum;
    logic toggle_now;
    logic core_rise;

    assign ext_edge = ext_clock_in ^ ext_prev_reg;
    assign ext_rise = ext_clock_in & ~ext_prev_reg;
    assign mf = eff_factor(mult_reg);
    assign df = eff_factor(div_reg);
    assign unity = (mf == FACTOR_RESET) && (df == FACTOR_RESET);
    assign acc_sum = acc_reg + (ext_edge ? {2'b00, mf} : {(FACTOR_W+2){1'b0}});

    // each input half period adds mf, each core half period costs df
    always_comb begin
        acc_next = acc_reg;
        toggle_now = 1'b0;
        if (!loop_enable_bit) begin
            // (RULE3) divide by two
            toggle_now = ext_rise;
            acc_next = '0;
        end else if (unity) begin
            toggle_now = ext_edge && (core_clock_out != ext_clock_in);
            acc_next = '0;
        end else begin
            // (RULE8) fractional ratio
            if (acc_sum >= {2'b00, df}) begin
                toggle_now = 1'b1;
                acc_next = acc_sum - {2'b00, df};
            end else begin
                acc_next = acc_sum;
            end
        end
    end

    assign core_rise = toggle_now & ~core_clock_out;

    // input sampling and crystal drive (inverting oscillator stage)
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ext_prev_reg <= ext_clock_in; // tracks the pin: no false edge at release
            crystal_drive_out <= 1'b1;
        end else begin
            ext_prev_reg <= ext_clock_in;
            crystal_drive_out <= ~ext_clock_in;
        end
    end

    // ************************************************************
    // core clock phase, driven out directly
    // ************************************************************
    // a large ratio makes toggles bunch up one per mclk cycle; the
    // average rate is right but the waveform is not evenly spaced
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            core_clock_out <= 1'b0;
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            // (RULE1) output is the core phase
            if (loop_enable_bit && unity && ext_edge) begin
                // (RULE2) locked to input
                core_clock_out <= ext_clock_in;
            end else if (toggle_now) begin
                core_clock_out <= ~core_clock_out;
            end
        end
    end

    // ************************************************************
    // loop strap and software control registers
    // ************************************************************
    logic wr_take;
    assign wr_take = psel && penable && pready && pwrite;

    // (RULE4) strap caught while reset is held
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            loop_enable_bit <= loop_init_pin;
        end else if (wr_take && (paddr == LOOP_CTRL_OFS)) begin
            loop_enable_bit <= pwdata[LOOP_EN_BIT];
        end
    end

    // factors and operating mode
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mult_reg <= FACTOR_RESET;
            div_reg <= FACTOR_RESET;
            async_arbitration_enable <= 1'b0;
        end else if (wr_take) begin
            if (paddr == LOOP_CTRL_OFS) begin
                mult_reg <= pwdata[MULT_LSB +: FACTOR_W];
                div_reg <= pwdata[DIV_LSB +: FACTOR_W];
            end else if (paddr == OP_MODE_OFS) begin
                async_arbitration_enable <= pwdata[ASYNC_ARB_BIT];
            end
        end
    end

    // ************************************************************
    // non-maskable interrupt
    // ************************************************************
    // prev follows the pin in reset so a low level at release is no edge
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            nmi_prev_reg <= nmi_n;
            nmi_pend_reg <= 1'b0;
            nmi_request <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_n;
            // (RULE5) falling edge, delivered at clock output rise
            nmi_request <= nmi_pend_reg && core_rise;
            if (nmi_prev_reg && !nmi_n) begin
                nmi_pend_reg <= 1'b1;
            end else if (core_rise) begin
                nmi_pend_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // bus arbitration inputs
    // ************************************************************
    level_sync #(
        .WIDTH(2)
    ) u_arb_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .async_in({bus_busy, bus_grant}),
        .sync_out(arb_sync)
    );

    // sync mode samples only at clock output rise; async mode needs no
    // timing to it but costs two cycles of synchroniser latency
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bus_busy_seen <= 1'b0;
            bus_grant_seen <= 1'b0;
            async_arb_mode <= 1'b0;
        end else begin
            // (RULE6) arbitration mode select
            async_arb_mode <= async_arbitration_enable;
            if (async_arbitration_enable) begin
                bus_busy_seen <= arb_sync[1];
                bus_grant_seen <= arb_sync[0];
            end else if (core_rise) begin
                bus_busy_seen <= bus_busy;
                bus_grant_seen <= bus_grant;
            end
        end
    end

    // ************************************************************
    // apb slave: one wait cycle, unmapped reads zero with error
    // ************************************************************
    logic [31:0] rd_word;
    logic rd_ok;

    // read mux
    always_comb begin
        rd_word = WORD_ZERO;
        rd_ok = 1'b1;
        if (paddr == LOOP_CTRL_OFS) begin
            rd_word[MULT_LSB +: FACTOR_W] = mult_reg;
            rd_word[DIV_LSB +: FACTOR_W] = div_reg;
            rd_word[LOOP_EN_BIT] = loop_enable_bit;
        end else if (paddr == OP_MODE_OFS) begin
            rd_word[ASYNC_ARB_BIT] = async_arbitration_enable;
        end else if (paddr == STATUS_OFS) begin
            rd_word[ST_CLK_BIT] = core_clock_out;
            rd_word[ST_NMI_BIT] = nmi_pend_reg;
            rd_word[ST_BUSY_BIT] = bus_busy_seen;
            rd_word[ST_GRANT_BIT] = bus_grant_seen;
            rd_word[ST_ASYNC_BIT] = async_arb_mode;
            rd_word[ST_EN_BIT] = loop_enable_bit;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // answer state machine
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bus_state_reg <= BUS_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= WORD_ZERO;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (psel && penable) begin
                        bus_state_reg <= BUS_ANSWER;
                        pready <= 1'b1;
                        pslverr <= ~rd_ok;
                        prdata <= pwrite ? WORD_ZERO : rd_word;
                    end
                end
                BUS_ANSWER: begin
                    bus_state_reg <= BUS_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // (RULE1) output moves only on a core phase step
    core_phase_a: assert property ($changed(core_clock_out) |-> $past(toggle_now)) // (RULE1)
        else $error("clock output moved without a core phase step");

    // (RULE2) unity ratio tracks the input clock
    unity_track_a: assert property ( // (RULE2)
        reset_n && loop_enable_bit && unity && ext_edge |=> core_clock_out == $past(ext_clock_in))
        else $error("clock output not aligned to input clock");

    // (RULE3) half rate when loop is off
    half_rate_a: assert property ( // (RULE3)
        !loop_enable_bit && !ext_rise |=> $stable(core_clock_out))
        else $error("clock output moved without input rise");
    half_step_a: assert property ( // (RULE3)
        reset_n && !loop_enable_bit && ext_rise |=> core_clock_out != $past(core_clock_out))
        else $error("clock output missed an input rise");

    // (RULE4) strap copy
    // only meaningful while reset is held, so the default disable is overridden
    strap_copy_a: assert property (@(posedge mclk) disable iff (1'b0) // (RULE4)
        !reset_n ##1 !reset_n |-> loop_enable_bit == $past(loop_init_pin))
        else $error("loop enable did not follow the init pin");

    // (RULE5) request only together with clock output rise
    nmi_sync_a: assert property (nmi_request |-> $rose(core_clock_out)) // (RULE5)
        else $error("nmi request not aligned to clock output");

    // (RULE6) sync mode holds the busy sample between rises
    arb_hold_a: assert property ( // (RULE6)
        !async_arbitration_enable && !core_rise |=> $stable(bus_busy_seen))
        else $error("busy sample changed off clock output rise");

    // (RULE8) ratio accumulator stays below one divider step plus one multiplier step
    ratio_acc_a: assert property ( // (RULE8)
        loop_enable_bit && !unity && !ext_edge |=> acc_reg < {2'b00, df} + {2'b00, mf})
        else $error("ratio accumulator out of range");

    nmi_cov_c: cover property (nmi_request);
    unity_cov_c: cover property (loop_enable_bit && unity && ext_rise);
    frac_cov_c: cover property (loop_enable_bit && !unity && core_rise);
    async_cov_c: cover property (async_arb_mode && $changed(bus_grant_seen));

endmodule : clock_pll_output_control

// ===== tb/ext_clock_source.sv
// free-running clock source standing in for the crystal
`timescale 1ns/1ps
module ext_clock_source (
    input wire logic mclk,
    input wire logic [7:0] half_cycles,
    output logic ext_clock_in
);
    logic [7:0] count_reg = 8'h00;
    // slow source
    // far below 100 MHz; a crystal runs free, so no standing still between uses
    always @(posedge mclk) begin
        if (count_reg + 8'h01 >= half_cycles) begin
            count_reg <= 8'h00;
            ext_clock_in <= ~ext_clock_in;
        end else begin
            count_reg <= count_reg + 8'h01;
        end
    end
    initial ext_clock_in = 1'b0;
endmodule : ext_clock_source

// ===== tb/clock_pll_output_control_test.sv
// self-checking bench for the clock generation and output block
`timescale 1ns/1ps
module clock_pll_output_control_test;
    import clk_ctrl_pkg::*;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, half_cycles;
    logic [31:0] pwdata, prdata, rdata;
    logic ext_clock_in, crystal_drive_out, core_clock_out, loop_init_pin;
    logic nmi_n, nmi_request, bus_busy, bus_grant, bus_busy_seen, bus_grant_seen;
    logic async_arb_mode, core_prev, ext_d1;
    int mismatches, checked, cyc, rises, nmi_pulses;

    clock_pll_output_control clock_pll_output_control_i (
        .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clock_in(ext_clock_in),
        .crystal_drive_out(crystal_drive_out), .core_clock_out(core_clock_out),
        .loop_init_pin(loop_init_pin), .nmi_n(nmi_n), .nmi_request(nmi_request),
        .bus_busy(bus_busy), .bus_grant(bus_grant), .bus_busy_seen(bus_busy_seen),
        .bus_grant_seen(bus_grant_seen), .async_arb_mode(async_arb_mode)
    );
    ext_clock_source ext_clock_source_i (
        .mclk(mclk), .half_cycles(half_cycles), .ext_clock_in(ext_clock_in)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // history of outputs, read before this edge's updates land
    always @(posedge mclk) begin
        core_prev <= core_clock_out;
        ext_d1 <= ext_clock_in;
        if (nmi_request === 1'b1) nmi_pulses <= nmi_pulses + 1;
        cyc <= cyc + 1;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check("pready", 32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle so the next call never re-drives psel in this step
        @(posedge mclk);
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] mask,
                          input logic [31:0] exp);
        apb(1'b0, a, WORD_ZERO, rdata, err);
        check(name, rdata & mask, exp);
    endtask : rd_chk

    // waits for a rise of the clock output, bounded
    task automatic core_rise();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!(core_clock_out === 1'b1 && core_prev === 1'b0) && n < 400);
        if (n >= 400) check("core rise", 32'h0, 32'h1);
    endtask : core_rise

    task automatic do_reset(input logic strap, input logic nmi_level);
        @(posedge mclk);
        reset_n <= 1'b0;
        loop_init_pin <= strap;
        nmi_n <= nmi_level;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
    endtask : do_reset

    task automatic half_period_check(input int h);
        half_cycles <= 8'(h);
        repeat (3) core_rise();
        rises = cyc;
        core_rise();
        check("core period", 32'(cyc - rises), 32'(4 * h));
    endtask : half_period_check
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, loop_init_pin, bus_busy, bus_grant} = 6'h00;
        paddr = 8'h00;
        pwdata = WORD_ZERO;
        nmi_n = 1'b1;
        half_cycles = 8'h04;
        {core_prev, ext_d1} = 2'h0;
        {mismatches, checked, cyc} = {32'h0, 32'h0, 32'h0};
        nmi_pulses = 0;
        do_reset(1'b0, 1'b1);
        rd_chk("loop ctrl", LOOP_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0101);
        rd_chk("status enable", STATUS_OFS, 32'h0000_0020, 32'h0000_0000);
        // unmapped place: error, no data, write lost
        apb(1'b1, 8'h0C, 32'h0001_0000, rdata, err);
        check("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h0C, WORD_ZERO, rdata, err);
        check("unmapped data", rdata, WORD_ZERO);
        for (int h = 3; h <= 5; h++) half_period_check(h);
        // falling nmi: exactly one request, on a clock output rise
        nmi_n <= 1'b0;
        rises = 0;
        repeat (200) begin
            @(posedge mclk);
            if (nmi_request === 1'b1) begin
                rises++;
                check("nmi on rise", {30'h0, core_clock_out, core_prev}, 32'h2);
            end
        end
        check("nmi count", 32'(rises), 32'h1);
        nmi_n <= 1'b1;
        rises = nmi_pulses;
        do_reset(1'b1, 1'b0);
        rd_chk("loop ctrl", LOOP_CTRL_OFS, 32'hFFFF_FFFF, 32'h0001_0101);
        rd_chk("status enable", STATUS_OFS, 32'h0000_0020, 32'h0000_0020);
        // counted from before reset, so a stray pulse at release is caught too
        repeat (100) @(posedge mclk);
        check("nmi in reset", 32'(nmi_pulses - rises), 32'h0);
        half_cycles <= 8'h04;
        repeat (20) @(posedge mclk);
        repeat (40) begin
            @(posedge mclk);
            check("core follows input", {31'h0, core_clock_out}, {31'h0, ext_d1});
            check("crystal drive", {31'h0, crystal_drive_out}, {31'h0, ~ext_d1});
        end
        // ratio three over two: 48 input edges give 36 rises, one either way
        apb(1'b1, LOOP_CTRL_OFS, 32'h0001_0203, rdata, err);
        rd_chk("loop ctrl", LOOP_CTRL_OFS, 32'hFFFF_FFFF, 32'h0001_0203);
        repeat (20) @(posedge mclk);
        rises = 0;
        repeat (192) begin
            @(posedge mclk);
            if (core_clock_out === 1'b1 && core_prev === 1'b0) rises++;
        end
        check("ratio rises", 32'(rises >= 35 && rises <= 37), 32'h1);
        apb(1'b1, LOOP_CTRL_OFS, 32'h0000_0203, rdata, err);
        half_period_check(4);
        bus_busy <= 1'b1;
        bus_grant <= 1'b1;
        repeat (2) core_rise();
        check("sync seen", {30'h0, bus_busy_seen, bus_grant_seen}, 32'h3);
        apb(1'b1, OP_MODE_OFS, 32'h0000_0001, rdata, err);
        rd_chk("async status", STATUS_OFS, 32'h0000_0010, 32'h0000_0010);
        check("async mode", {31'h0, async_arb_mode}, 32'h1);
        bus_busy <= 1'b0;
        repeat (2) @(posedge mclk);
        check("busy held", {31'h0, bus_busy_seen}, 32'h1);
        repeat (2) @(posedge mclk);
        check("busy async", {31'h0, bus_busy_seen}, 32'h0);
        print_verdict();
    end
    // watchdog: the sequence needs under 3000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        print_verdict();
    end
endmodule : clock_pll_output_control_test
